// ### src/rpmii_pkg.sv
package rpmii_pkg;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_RX_COUNT = 8'h08;
    localparam logic [7:0] ADR_TX_COUNT = 8'h0C;

    // parallel_port_control field positions
    localparam int CTRL_SPD_LO  = 0;
    localparam int CTRL_SPD_HI  = 1;
    localparam int CTRL_DDR     = 2;
    localparam int CTRL_DIR     = 3;
    localparam int CTRL_PLL_OUT = 4;

    // values after reset for the fields that straps do not set
    localparam logic RST_DIR     = 1'h1;
    localparam logic RST_PLL_OUT = 1'h0;

    // speed codes shared by straps and software
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_RTBI = 2'h3;

    // link rates in kHz, scaled onto clk_i half periods in inverse proportion
    localparam int RATE_1000_KHZ = 125_000;
    localparam int RATE_100_KHZ  = 25_000;
    localparam int RATE_10_KHZ   = 2_500;
    localparam logic [5:0] HALF_1000 = 6'(RATE_1000_KHZ / RATE_1000_KHZ);
    localparam logic [5:0] HALF_100  = 6'(RATE_1000_KHZ / RATE_100_KHZ);
    localparam logic [5:0] HALF_10   = 6'(RATE_1000_KHZ / RATE_10_KHZ);

    localparam logic [15:0] COUNT_RST = 16'h0000;

    typedef enum logic [2:0] {
        MODE_OFF   = 3'b000,
        MODE_R10   = 3'b001,
        MODE_R100  = 3'b010,
        MODE_R1000 = 3'b011,
        MODE_RTBI  = 3'b100,
        MODE_MII10 = 3'b101,
        MODE_MII100 = 3'b110
    } port_mode_t;

endpackage

// ### src/reduced_parallel_mii_port.sv
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module reduced_parallel_mii_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // reset straps
    input  wire logic        strap_col_i,
    input  wire logic        strap_crs_i,
    input  wire logic [1:0]  strap_rxd_i,
    // parallel receive side
    output logic      [3:0]  rxd_o,
    output logic             rx_ctl_o,
    output logic             rx_er_o,
    output logic             crs_o,
    output logic             col_o,
    input  wire logic        rx_clk_i,
    output logic             rx_clk_o,
    output logic             rx_clk_oe_o,
    // parallel transmit side
    input  wire logic [3:0]  txd_i,
    input  wire logic        tx_ctl_i,
    input  wire logic        gigabit_tx_clock_in_i,
    input  wire logic        tx_clk_i,
    output logic             tx_clk_o,
    output logic             tx_clk_oe_o,
    // serial side
    input  wire logic        ser_rx_valid_i,
    input  wire logic [9:0]  ser_rx_data_i,
    input  wire logic        ser_rx_err_i,
    input  wire logic        ser_signal_i,
    output logic             ser_rx_take_o,
    output logic             ser_tx_valid_o,
    output logic      [9:0]  ser_tx_data_o,
    output logic             ser_tx_err_o,
    output logic             ser_rx_clk_src_o
);
    import rpmii_pkg::*;

    localparam int NPIN = 12;

    // pin synchronisers: 0 gtx, 1 tx clk, 2 rx clk, 3 tx ctl, 7:4 txd, 8 col, 9 crs, 11:10 rxd strap
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] filt;
    logic [NPIN-1:0] filt_d;
    wire  [NPIN-1:0] pin_in = {strap_rxd_i, strap_crs_i, strap_col_i, txd_i, tx_ctl_i,
                               rx_clk_i, tx_clk_i, gigabit_tx_clock_in_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (ce_i) begin
                    s1[g]     <= pin_in[g];
                    s2[g]     <= s1[g];
                    s3[g]     <= s2[g];
                    filt[g]   <= (s2[g] == s3[g]) ? s3[g] : filt[g];
                    filt_d[g] <= filt[g];
                end
            end
        end
    endgenerate

    wire [NPIN-1:0] pin_rise = filt & ~filt_d;
    wire [NPIN-1:0] pin_fall = ~filt & filt_d;

    // control register
    logic [1:0]  spd;
    logic        ddr;
    logic        dir_dce;
    logic        pll_out;
    logic        strap_done;
    logic        rx_busy;
    logic        tx_busy;
    logic [15:0] rx_units;
    logic [15:0] tx_units;

    // mode decode
    wire        is_ddr_mode = ddr;
    wire        mii_ok      = ~ddr & ~spd[1];
    port_mode_t mode;
    assign mode = !strap_done ? MODE_OFF :
                  is_ddr_mode ? ((spd == SPD_RTBI) ? MODE_RTBI :
                                 (spd == SPD_1000) ? MODE_R1000 :
                                 (spd == SPD_100)  ? MODE_R100 : MODE_R10) :
                  mii_ok ? (spd[0] ? MODE_MII100 : MODE_MII10) : MODE_OFF;

    wire is_rtbi   = (mode == MODE_RTBI);
    wire is_wide   = (mode == MODE_R1000) | is_rtbi;
    wire is_rg_lo  = (mode == MODE_R10) | (mode == MODE_R100);
    wire is_rgmii  = is_wide | is_rg_lo;
    wire is_mii    = (mode == MODE_MII10) | (mode == MODE_MII100);
    wire is_dte    = is_mii & ~dir_dce;
    wire active    = is_rgmii | is_mii;

    // half period follows the current speed code on every rx reload; tx reloads in RGMII modes use HALF_1000
    wire [5:0] half_len = is_wide ? HALF_1000 :
                          ((mode == MODE_R100) | (mode == MODE_MII100)) ? HALF_100 : HALF_10;

    // wishbone decode
    wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ctrl  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);
    wire [31:0] status_word = {25'h000_0000, strap_done, tx_busy, rx_busy, ser_signal_i, mode};
    wire [31:0] ctrl_word   = {27'h000_0000, pll_out, dir_dce, ddr, spd};
    wire [31:0] rd_word = (wb_adr_i == ADR_CTRL)     ? ctrl_word :
                          (wb_adr_i == ADR_STATUS)   ? status_word :
                          (wb_adr_i == ADR_RX_COUNT) ? {16'h0000, rx_units} :
                          (wb_adr_i == ADR_TX_COUNT) ? {16'h0000, tx_units} : 32'h0000_0000;

    // strap decode, taken once from the filtered pins after reset
    wire       st_col = filt[8];
    wire       st_crs = filt[9];
    wire [1:0] st_rxd = filt[11:10];
    wire [1:0] st_spd = (st_col & st_crs) ? SPD_1000 : st_rxd;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spd        <= SPD_10;
            ddr        <= 1'b0;
            dir_dce    <= RST_DIR;
            pll_out    <= RST_PLL_OUT;
            strap_done <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= rd_word;
            end
            if (!strap_done) begin
                strap_done <= 1'b1;
                spd        <= st_spd;
                ddr        <= st_crs;
            end else if (wr_ctrl) begin
                spd     <= wb_dat_i[CTRL_SPD_HI:CTRL_SPD_LO];
                ddr     <= wb_dat_i[CTRL_DDR];
                dir_dce <= wb_dat_i[CTRL_DIR];
                pll_out <= wb_dat_i[CTRL_PLL_OUT];
            end
        end
    end

    // ---------------- receive path ----------------
    logic [5:0] rx_cnt;
    logic       nib_hi;
    logic [9:0] rx_hold;
    logic       rx_hold_er;

    // receive clock is divided from clk_i in every driven mode
    wire rx_tick    = active & ~is_dte & (rx_cnt == 6'h00);
    wire rx_rise_ev = is_dte ? pin_fall[2] : (rx_tick & ~rx_clk_o);
    wire rx_fall_ev = rx_tick & rx_clk_o & is_rgmii;
    wire can_take   = ser_rx_valid_i & ~ser_rx_take_o;
    wire take_wide  = rx_rise_ev & is_wide & can_take;
    wire take_nib   = rx_rise_ev & ~is_wide & ~nib_hi & can_take;
    wire take_now   = take_wide | take_nib;
    wire [9:0] rtbi_fall = {rx_hold[9], rx_hold[5], rx_hold[6], rx_hold[7], rx_hold[8],
                            rx_hold[4:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_cnt        <= 6'h00;
            rx_clk_o      <= 1'b0;
            rx_clk_oe_o   <= 1'b0;
            rxd_o         <= 4'h0;
            rx_ctl_o      <= 1'b0;
            rx_er_o       <= 1'b0;
            crs_o         <= 1'b0;
            col_o         <= 1'b0;
            rx_busy       <= 1'b0;
            nib_hi        <= 1'b0;
            rx_hold       <= 10'h000;
            rx_hold_er    <= 1'b0;
            ser_rx_take_o <= 1'b0;
            rx_units      <= COUNT_RST;
            ser_rx_clk_src_o <= 1'b0;
        end else if (ce_i) begin
            ser_rx_take_o <= take_now;
            rx_clk_oe_o   <= active & ~is_dte;
            col_o         <= 1'b0;
            ser_rx_clk_src_o <= ser_signal_i;
            if (!active || is_dte) begin
                rx_cnt   <= 6'h00;
                rx_clk_o <= 1'b0;
            end else if (rx_tick) begin
                rx_cnt   <= half_len - 6'h01;
                rx_clk_o <= ~rx_clk_o;
            end else begin
                rx_cnt <= rx_cnt - 6'h01;
            end
            if (!active) begin
                rxd_o    <= 4'h0;
                rx_ctl_o <= 1'b0;
                rx_er_o  <= 1'b0;
                crs_o    <= 1'b0;
                rx_busy  <= 1'b0;
                nib_hi   <= 1'b0;
            end else if (rx_rise_ev) begin
                if (take_now) begin
                    rx_hold    <= ser_rx_data_i;
                    rx_hold_er <= ser_rx_err_i & ~is_rtbi;
                    rxd_o      <= ser_rx_data_i[3:0];
                    rx_ctl_o   <= is_rtbi ? ser_rx_data_i[4] : 1'b1;
                    rx_er_o    <= is_mii & ser_rx_err_i;
                    crs_o      <= ~is_rtbi;
                    rx_busy    <= 1'b1;
                    nib_hi     <= ~is_wide;
                    rx_units   <= rx_units + 16'h0001;
                end else if (nib_hi) begin
                    // second nibble keeps the byte whole, so preamble stays even
                    rxd_o    <= rx_hold[7:4];
                    rx_ctl_o <= 1'b1;
                    nib_hi   <= 1'b0;
                end else begin
                    // idle shows plain zeros, never link or speed status
                    rxd_o    <= 4'h0;
                    rx_ctl_o <= 1'b0;
                    rx_er_o  <= 1'b0;
                    crs_o    <= 1'b0;
                    rx_busy  <= 1'b0;
                    // clear the held unit so idle falling edges show zeros too
                    rx_hold    <= 10'h000;
                    rx_hold_er <= 1'b0;
                end
            end else if (rx_fall_ev) begin
                if (is_wide) begin
                    rxd_o <= is_rtbi ? rtbi_fall[8:5] : rx_hold[7:4];
                end
                // nibble modes leave rxd_o untouched through the falling edge
                rx_ctl_o <= is_rtbi ? rx_hold[9] : (rx_busy ^ rx_hold_er);
            end
        end
    end

    // ---------------- transmit path ----------------
    logic [5:0] tx_cnt;
    logic       tx_hi;
    logic [3:0] tx_lo;
    logic       tx_c0;

    wire       tx_drive   = (is_rgmii & pll_out) | (is_mii & dir_dce);
    wire [5:0] tx_half    = is_rgmii ? HALF_1000 : half_len;
    wire       tx_tick    = tx_drive & (tx_cnt == 6'h00);
    // the transmit clock only paces capture; serial timing never comes from it
    wire       tx_rise_ev = is_rgmii ? pin_rise[0] :
                            is_dte ? pin_rise[1] :
                            (is_mii & tx_tick & tx_clk_o);
    wire       tx_fall_ev = is_wide & pin_fall[0];
    wire [3:0] p_txd      = filt[7:4];
    wire       p_ctl      = filt[3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_cnt         <= 6'h00;
            tx_clk_o       <= 1'b0;
            tx_clk_oe_o    <= 1'b0;
            tx_busy        <= 1'b0;
            tx_hi          <= 1'b0;
            tx_lo          <= 4'h0;
            tx_c0          <= 1'b0;
            ser_tx_valid_o <= 1'b0;
            ser_tx_data_o  <= 10'h000;
            ser_tx_err_o   <= 1'b0;
            tx_units       <= COUNT_RST;
        end else if (ce_i) begin
            ser_tx_valid_o <= 1'b0;
            ser_tx_err_o   <= 1'b0;
            tx_clk_oe_o    <= tx_drive;
            if (!tx_drive) begin
                tx_cnt   <= 6'h00;
                tx_clk_o <= 1'b0;
            end else if (tx_tick) begin
                tx_cnt   <= tx_half - 6'h01;
                tx_clk_o <= ~tx_clk_o;
            end else begin
                tx_cnt <= tx_cnt - 6'h01;
            end
            if (!active) begin
                tx_busy <= 1'b0;
                tx_hi   <= 1'b0;
            end else if (tx_rise_ev) begin
                tx_c0 <= p_ctl;
                if (is_wide) begin
                    tx_lo <= p_txd;
                end else if (p_ctl) begin
                    // enable alone decides; the error half is discarded
                    tx_busy <= 1'b1;
                    if (!tx_hi) begin
                        tx_lo <= p_txd;
                        tx_hi <= 1'b1;
                    end else begin
                        ser_tx_valid_o <= 1'b1;
                        ser_tx_data_o  <= {2'h0, p_txd, tx_lo};
                        tx_hi          <= 1'b0;
                        tx_units       <= tx_units + 16'h0001;
                    end
                end else begin
                    // an odd trailing nibble is dropped with the frame end
                    tx_busy <= 1'b0;
                    tx_hi   <= 1'b0;
                end
            end else if (tx_fall_ev) begin
                if (is_rtbi) begin
                    ser_tx_valid_o <= 1'b1;
                    ser_tx_data_o  <= {p_ctl, p_txd[0], p_txd[1], p_txd[2], p_txd[3],
                                       tx_c0, tx_lo};
                    tx_units       <= tx_units + 16'h0001;
                end else if (tx_c0) begin
                    // pairs 1,0 and 1,1 both carry data; 0,x is idle
                    ser_tx_valid_o <= 1'b1;
                    ser_tx_data_o  <= {2'h0, p_txd, tx_lo};
                    tx_units       <= tx_units + 16'h0001;
                end
                tx_busy <= tx_c0 & ~is_rtbi;
            end
        end
    end

endmodule
`default_nettype wire

// ### dv/rpmii_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rpmii_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [3:0] rxd_o,
    input wire logic       crs_o,
    input wire logic       col_o,
    input wire logic       rx_clk_o,
    input wire logic       rx_clk_oe_o,
    input wire logic       ser_rx_valid_i,
    input wire logic       ser_rx_take_o,
    input wire logic       ser_signal_i,
    input wire logic       ser_rx_clk_src_o,
    input wire logic       ser_tx_valid_o,
    input wire logic       ser_tx_err_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_late;
        s_req |=> s_ack_pulse;
    endproperty
    a_ack_late: assert property (p_ack_late) else $error("ack not one cycle after request");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_no_col;
        !col_o && !ser_tx_err_o;
    endproperty
    a_no_col: assert property (p_no_col) else $error("collision or tx error driven");
    property p_take_cause;
        ser_rx_take_o |-> $past(ser_rx_valid_i) ##1 !ser_rx_take_o;
    endproperty
    a_take_cause: assert property (p_take_cause) else $error("bad take pulse");
    property p_tx_pulse;
        ser_tx_valid_o |=> !ser_tx_valid_o;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx valid longer than one cycle");
    property p_rxd_edge;
        (rx_clk_oe_o && crs_o && $past(crs_o) && $changed(rxd_o)) |-> $changed(rx_clk_o);
    endproperty
    a_rxd_edge: assert property (p_rxd_edge) else $error("rx data moved off a clock edge");
    property p_src_follow;
        (!$past(rst_i) && $past(ce_i)) |-> ser_rx_clk_src_o == $past(ser_signal_i);
    endproperty
    a_src_follow: assert property (p_src_follow) else $error("rx clock source wrong");
    property p_rx_half;
        $rose(rx_clk_o) |-> ##[1:50] $fell(rx_clk_o);
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("rx clock high too long");
endmodule
bind reduced_parallel_mii_port rpmii_checker chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rxd_o,
    .crs_o, .col_o, .rx_clk_o, .rx_clk_oe_o, .ser_rx_valid_i, .ser_rx_take_o, .ser_signal_i, .ser_rx_clk_src_o,
    .ser_tx_valid_o, .ser_tx_err_o);
`default_nettype wire

// ### dv/rgmii_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module rgmii_mac_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       send_i,
    input  wire logic [9:0] code_i,
    output logic            gtx_o,
    output logic      [3:0] txd_o,
    output logic            tx_ctl_o,
    output logic            busy_o
);
    logic [3:0] step;
    initial {gtx_o, tx_ctl_o, txd_o} = 6'h00;
    assign busy_o = (step != 4'h0);
    // clock stands still low between units; data settles 2 cycles before the rising edge and 3 before the falling, holds 3 after each
    always @(posedge clk_i) begin
        if (rst_i) begin
            step <= 4'h0;
            gtx_o <= 1'b0;
        end else if (busy_o || send_i) begin
            step <= (step == 4'hB) ? 4'h0 : step + 4'h1;
            case (step)
                4'h0: {tx_ctl_o, txd_o} <= code_i[4:0];
                4'h2: gtx_o <= 1'b1;
                4'h5: {tx_ctl_o, txd_o} <= code_i[9:5];
                4'h8: gtx_o <= 1'b0;
                4'hB: {tx_ctl_o, txd_o} <= ~{tx_ctl_o, txd_o};
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rpmii_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, rx_clk_i = 1'b0, tx_clk_i = 1'b0, send = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, strap_col_i = 1'b0, strap_crs_i = 1'b1;
    logic        ser_rx_valid_i = 1'b0, ser_rx_err_i = 1'b0, ser_signal_i = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic [1:0]  strap_rxd_i = 2'h1;
    logic [9:0]  ser_rx_data_i = 10'h000, code = 10'h000, ser_tx_data_o, tx_seen;
    logic [3:0]  rxd_o, txd_i;
    logic        wb_ack_o, rx_ctl_o, rx_er_o, crs_o, col_o, rx_clk_o, rx_clk_oe_o, tx_ctl_i, mac_busy;
    logic        gigabit_tx_clock_in_i, tx_clk_o, tx_clk_oe_o, ser_rx_take_o, ser_tx_valid_o;
    logic        ser_tx_err_o, ser_rx_clk_src_o;
    int          bad_count = 0, checks_done = 0, cycles = 0, tx_n = 0;
    logic [4:0]  mode_ctl [7] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h08, 5'h09, 5'h0B};
    port_mode_t  mode_exp [7] = '{MODE_R10, MODE_R100, MODE_R1000, MODE_RTBI, MODE_MII10, MODE_MII100, MODE_OFF};

    always #25 clk_i = ~clk_i;

    // free-running neighbour MII clocks, used only in DTE mode
    always @(posedge clk_i) begin
        if (cycles % 5 == 4) begin
            rx_clk_i <= ~rx_clk_i;
            tx_clk_i <= ~tx_clk_i;
        end
    end

    reduced_parallel_mii_port uut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .strap_col_i, .strap_crs_i, .strap_rxd_i, .rxd_o, .rx_ctl_o, .rx_er_o,
        .crs_o, .col_o, .rx_clk_i, .rx_clk_o, .rx_clk_oe_o, .txd_i, .tx_ctl_i, .gigabit_tx_clock_in_i, .tx_clk_i,
        .tx_clk_o, .tx_clk_oe_o, .ser_rx_valid_i, .ser_rx_data_i, .ser_rx_err_i, .ser_signal_i, .ser_rx_take_o,
        .ser_tx_valid_o, .ser_tx_data_o, .ser_tx_err_o, .ser_rx_clk_src_o);
    rgmii_mac_model mac (.clk_i, .rst_i, .send_i(send), .code_i(code), .gtx_o(gigabit_tx_clock_in_i),
        .txd_o(txd_i), .tx_ctl_o(tx_ctl_i), .busy_o(mac_busy));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // whole run takes under two thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ser_tx_valid_o === 1'b1) begin
            tx_n <= tx_n + 1;
            tx_seen <= ser_tx_data_o;
        end
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    function automatic logic [9:0] tbi(input logic [9:0] g);
        return {g[9], g[5], g[6], g[7], g[8], g[4], g[3:0]};
    endfunction

    function automatic logic [9:0] rg_tx(input logic [7:0] b, input logic en, input logic er);
        return {en ^ er, b[7:4], en, b[3:0]};
    endfunction

    function automatic logic [19:0] rg_exp(input logic [7:0] b, input logic er, input logic nib);
        if (nib) begin
            return {~er, b[7:4], 1'b1, b[7:4], ~er, b[3:0], 1'b1, b[3:0]};
        end
        return {10'h000, rg_tx(b, 1'b1, er)};
    endfunction

    task automatic do_reset(input logic col, input logic [1:0] rxd);
        rst_i <= 1'b1;
        strap_col_i <= col;
        strap_rxd_i <= rxd;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rx_unit(input logic [9:0] d, input logic er, input int n, input logic [19:0] e, input int half);
        int k;
        ser_rx_data_i <= d;
        ser_rx_err_i <= er;
        ser_rx_valid_i <= 1'b1;
        @(negedge clk_i);
        while (!(rx_clk_o === 1'b1 && ser_rx_take_o === 1'b1)) @(negedge clk_i);
        check({rx_ctl_o, rxd_o}, e[4:0]);
        @(posedge clk_i);
        ser_rx_valid_i <= 1'b0;
        ser_rx_data_i <= ~d;
        k = 1;
        @(negedge clk_i);
        while (rx_clk_o === 1'b1) begin
            k++;
            @(negedge clk_i);
        end
        check(k, half);
        for (int p = 1; p < n; p++) begin
            while (rx_clk_o === p[0]) @(negedge clk_i);
            check({rx_ctl_o, rxd_o}, e[5*p +: 5]);
        end
        repeat (120) @(negedge clk_i);
        check({rx_ctl_o, rxd_o}, 5'h00);
        @(posedge clk_i);
    endtask

    task automatic tx_unit(input logic [9:0] c, input logic [9:0] m, input logic [9:0] x, input int cnt);
        int n0;
        n0 = tx_n;
        code <= c;
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        @(posedge clk_i);
        while (mac_busy === 1'b1) @(posedge clk_i);
        repeat (10) @(posedge clk_i);
        check(tx_n - n0, cnt);
        if (cnt != 0) check(tx_seen & m, x);
    endtask

    initial begin
        do_reset(1'b0, 2'h1);
        wb_io(1'b0, ADR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_000D);
        do_reset(1'b1, 2'h0);
        wb_io(1'b0, ADR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_000E);
        wb_io(1'b0, 8'h10, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wb_io(1'b1, ADR_STATUS, 32'hFFFF_FFFF);
        wb_io(1'b0, ADR_STATUS, 32'h0000_0000);
        check({29'h0, rd[2:0]}, {29'h0, MODE_R1000});
        for (int i = 0; i < 7; i++) begin
            wb_io(1'b1, ADR_CTRL, {27'h0, mode_ctl[i]});
            wb_io(1'b0, ADR_STATUS, 32'h0000_0000);
            check({29'h0, rd[2:0]}, {29'h0, mode_exp[i]});
        end
        for (int i = 0; i < 2; i++) begin
            wb_io(1'b1, ADR_CTRL, {27'h0, mode_ctl[i]});
            rx_unit(10'h0C3, 1'b1, 4, rg_exp(8'hC3, 1'b1, 1'b1), (i == 0) ? 50 : 5);
        end
        wb_io(1'b1, ADR_CTRL, {27'h0, mode_ctl[5]});
        rx_unit(10'h05A, 1'b0, 4, rg_exp(8'h5A, 1'b0, 1'b1), 5);
        wb_io(1'b1, ADR_CTRL, 32'h0000_0001);
        ser_rx_data_i <= 10'h0A5;
        ser_rx_err_i <= 1'b1;
        ser_rx_valid_i <= 1'b1;
        @(negedge clk_i);
        while (ser_rx_take_o !== 1'b1) @(negedge clk_i);
        check({rx_clk_oe_o, tx_clk_oe_o, rx_er_o, crs_o, rxd_o}, 8'h35);
        @(posedge clk_i);
        ser_rx_valid_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb_io(1'b1, ADR_CTRL, 32'h0000_001E);
        repeat (4) @(posedge clk_i);
        check(tx_clk_oe_o, 1'b1);
        rd[0] = tx_clk_o;
        @(posedge clk_i);
        check(tx_clk_o ^ rd[0], 1'b1);
        rx_unit(10'h0A5, 1'b0, 2, rg_exp(8'hA5, 1'b0, 1'b0), 1);
        rx_unit(10'h03C, 1'b1, 2, rg_exp(8'h3C, 1'b1, 1'b0), 1);
        tx_unit(rg_tx(8'h96, 1'b1, 1'b0), 10'h0FF, 10'h096, 1);
        tx_unit(rg_tx(8'h5A, 1'b1, 1'b1), 10'h0FF, 10'h05A, 1);
        tx_unit(rg_tx(8'h77, 1'b0, 1'b1), 10'h0FF, 10'h000, 0);
        wb_io(1'b1, ADR_CTRL, 32'h0000_000F);
        rx_unit(10'h2D3, 1'b0, 2, {10'h000, tbi(10'h2D3)}, 1);
        tx_unit(tbi(10'h1B6), 10'h3FF, 10'h1B6, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
